//--- logic/smbus_port_map.svh
/*
  constants of the serial register port: bus address, framing and pointer reset value.
  assumes inclusion by bare name from the logic/ folder.
*/
`ifndef SMBUS_PORT_MAP_SVH
`define SMBUS_PORT_MAP_SVH
`define DEV_ADDR_7    7'h2E
`define DEV_ADDR_WR   8'h5C
`define BITS_PER_BYTE 4'h8
`define ACK_SLOT      4'h8
`define PTR_RESET     8'h00
`endif

//--- logic/smbus_port_pkg.sv
/*
  types of the serial register port.
  uses no smbus_port_map.svh constants; the state codes are literal numbers.
*/
`default_nettype none
package smbus_port_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WCMD  = 3'b010,
    ST_WDATA = 3'b011,
    ST_READ  = 3'b100,
    ST_IGN   = 3'b101
  } link_state_e;
endpackage
`default_nettype wire

//--- logic/pin_sync.sv
/*
  two-stage synchroniser plus edge flags for the scl and sda pins.
  assumes pins are asynchronous to clk_i.
*/
`default_nettype none
module pin_sync (
  input  wire logic clk_i,     // system clock
  input  wire logic rst_b_i,   // async reset, low
  input  wire logic pin_i,     // raw pin level
  output logic      level_o,   // synchronised level
  output logic      rise_o,    // rising edge pulse
  output logic      fall_o     // falling edge pulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_s;
  sync_s q;
  sync_s next_q;
  always_comb begin
    next_q    = q;
    next_q.s1 = pin_i;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '1;
    end else begin
      q <= next_q;
    end
  end
  assign level_o = q.s2;
  assign rise_o  = q.s2 & ~q.s3;
  assign fall_o  = ~q.s2 & q.s3;
endmodule
`default_nettype wire

//--- logic/skid_buf.sv
/*
  two-entry buffer with valid/ready on both sides.
  assumes producer and consumer on clk_i.
*/
`default_nettype none
module skid_buf (
  input  wire logic       clk_i,    // system clock
  input  wire logic       rst_b_i,  // async reset, low
  input  wire logic [7:0] in_data_i,  // write data
  input  wire logic       in_valid_i, // write valid
  output logic            in_ready_o, // has room
  output logic [7:0]      out_data_o, // head data
  output logic            out_valid_o,// head valid
  input  wire logic       out_ready_i // consumer takes
);
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic [1:0]      cnt;
  } buf_s;
  buf_s q;
  buf_s next_q;
  logic push;
  logic pop;
  always_comb begin
    next_q = q;
    push   = in_valid_i & (q.cnt != 2'h2);
    pop    = out_ready_i & (q.cnt != 2'h0);
    if (pop) begin
      next_q.mem[0] = q.mem[1];
    end
    if (push) begin
      if (pop) begin
        next_q.mem[q.cnt[1] ? 1 : 0] = in_data_i;
      end else begin
        next_q.mem[q.cnt[0]] = in_data_i;
      end
    end
    next_q.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  assign in_ready_o  = (q.cnt != 2'h2);
  assign out_valid_o = (q.cnt != 2'h0);
  assign out_data_o  = q.mem[0];
endmodule
`default_nettype wire

//--- logic/smbus_reg_port.sv
/*
  smbus slave register port: address match, pointer, write and read byte.
  assumes the register bank sits outside, read data combinational from rd_addr_o,
  and the sda pad is open drain, resolved outside from sda_oe_o.
*/
`include "smbus_port_map.svh"
`default_nettype none
module smbus_reg_port (
  input  wire logic       clk_i,        // 200 MHz clock
  input  wire logic       rst_b_i,      // async reset, low
  input  wire logic       scl_i,        // scl pin level
  input  wire logic       sda_i,        // sda pin level
  output logic            sda_o,        // sda drive level, always 0
  output logic            sda_oe_o,     // high while pulling sda low
  output logic [7:0]      rd_addr_o,    // pointer to register bank
  input  wire logic [7:0] rd_data_i,    // register contents at pointer
  output logic [7:0]      wr_addr_o,    // write register address
  output logic [7:0]      wr_data_o,    // write data
  output logic            wr_valid_o,   // write request
  input  wire logic       wr_ready_i,   // bank accepts write
  output logic            busy_o        // addressed transfer active
);
  typedef struct packed {
    smbus_port_pkg::link_state_e st;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic        oe;
    logic        rd_nack;
    logic        busy;
    logic        wr_valid;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
  } port_s;

  port_s q;
  port_s next_q;

  logic scl;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic sda_rise;
  logic sda_fall;
  logic start_ev;
  logic stop_ev;
  logic push;
  logic buf_ready;
  logic [7:0] buf_data;
  logic       buf_valid;

  pin_sync u_scl (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pin_i   (scl_i),
    .level_o (scl),
    .rise_o  (scl_rise),
    .fall_o  (scl_fall)
  );

  pin_sync u_sda (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pin_i   (sda_i),
    .level_o (sda),
    .rise_o  (sda_rise),
    .fall_o  (sda_fall)
  );

  // sda edges during scl high are framing, not data
  assign start_ev = sda_fall & scl;
  assign stop_ev  = sda_rise & scl;

  // address and data ride in twin buffers that push and pop together
  logic       wbuf_ready;
  logic [7:0] wbuf_addr;

  always_comb begin
    next_q   = q;
    push     = 1'b0;
    next_q.wr_valid = q.wr_valid & ~wr_ready_i;
    if (!next_q.wr_valid && buf_valid) begin
      next_q.wr_valid = 1'b1;
      next_q.wr_addr  = wbuf_addr;
      next_q.wr_data  = buf_data;
    end
    if (start_ev) begin
      // new operation, pointer untouched
      next_q.st    = smbus_port_pkg::ST_ADDR;
      // the start's own scl fall wraps this to zero
      next_q.bitn  = 4'hF;
      next_q.oe    = 1'b0;
      next_q.busy  = 1'b0;
    end else if (stop_ev) begin
      next_q.st   = smbus_port_pkg::ST_IDLE;
      next_q.oe   = 1'b0;
      next_q.busy = 1'b0;
    end else if (scl_rise && q.st != smbus_port_pkg::ST_IDLE && q.st != smbus_port_pkg::ST_IGN) begin
      if (q.bitn < `BITS_PER_BYTE) begin
        next_q.shreg = {q.shreg[6:0], sda};
      end else if (q.st == smbus_port_pkg::ST_READ) begin
        next_q.rd_nack = sda;
      end
    end else if (scl_fall && q.st != smbus_port_pkg::ST_IDLE && q.st != smbus_port_pkg::ST_IGN) begin
      next_q.oe = 1'b0;
      if (q.bitn == `ACK_SLOT) begin
        next_q.bitn = 4'h0;
        if (q.st == smbus_port_pkg::ST_READ) begin
          if (q.rd_nack) begin
            next_q.st = smbus_port_pkg::ST_IGN;
          end else begin
            next_q.oe = ~rd_data_i[7];
            next_q.shreg = rd_data_i;
          end
        end
      end else begin
        next_q.bitn = q.bitn + 4'h1;
        if (q.st == smbus_port_pkg::ST_READ && q.bitn < 4'h7) begin
          // each rise shifts left, so the next bit sits on top
          next_q.oe = ~q.shreg[7];
        end
        if (q.bitn == 4'h7) begin
          // end of eight data bits: decide acknowledge
          unique case (q.st)
            smbus_port_pkg::ST_ADDR: begin
              if (q.shreg[7:1] == `DEV_ADDR_7) begin
                next_q.oe   = 1'b1;
                next_q.busy = 1'b1;
                next_q.st   = q.shreg[0] ? smbus_port_pkg::ST_READ : smbus_port_pkg::ST_WCMD;
                next_q.rd_nack = 1'b0;
              end else begin
                next_q.st = smbus_port_pkg::ST_IGN;
              end
            end
            smbus_port_pkg::ST_WCMD: begin
              next_q.ptr = q.shreg;
              next_q.oe  = 1'b1;
              next_q.st  = smbus_port_pkg::ST_WDATA;
            end
            smbus_port_pkg::ST_WDATA: begin
              // refuse when buffer full so no word is lost
              if (buf_ready) begin
                push      = 1'b1;
                next_q.oe = 1'b1;
                next_q.st = smbus_port_pkg::ST_IGN;
              end else begin
                next_q.st = smbus_port_pkg::ST_IGN;
              end
            end
            smbus_port_pkg::ST_READ: begin
              next_q.oe = 1'b0;
            end
            default: begin
              next_q.st = smbus_port_pkg::ST_IGN;
            end
          endcase
        end
      end
    end
    // leaving ack slot after ignoring: release still happens on fall
    if (scl_fall && q.st == smbus_port_pkg::ST_IGN) begin
      next_q.oe = 1'b0;
    end
  end

  // read data launched on ack fall: first bit driven then
  // (read byte reuses the same path after a pointer write)

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q       <= '0;
      q.ptr   <= `PTR_RESET;
    end else begin
      q <= next_q;
    end
  end

  skid_buf u_abuf (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   (q.ptr),
    .in_valid_i  (push),
    .in_ready_o  (),
    .out_data_o  (wbuf_addr),
    .out_valid_o (),
    .out_ready_i (wbuf_ready)
  );

  skid_buf u_wbuf (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   (q.shreg),
    .in_valid_i  (push),
    .in_ready_o  (buf_ready),
    .out_data_o  (buf_data),
    .out_valid_o (buf_valid),
    .out_ready_i (wbuf_ready)
  );

  // pop exactly when the output register takes the head word
  assign wbuf_ready = ~(q.wr_valid & ~wr_ready_i);

  // all register access goes through these ports only
  assign sda_o      = 1'b0;
  assign sda_oe_o   = q.oe;
  assign rd_addr_o  = q.ptr;
  assign wr_addr_o  = q.wr_addr;
  assign wr_data_o  = q.wr_data;
  assign wr_valid_o = q.wr_valid;
  assign busy_o     = q.busy;
endmodule
`default_nettype wire

//--- tb/smbus_reg_port_properties.sv
/*
  pin-level assertions on the serial register port.
  assumes one clock domain and binding to smbus_reg_port.
*/
`default_nettype none
module smbus_reg_port_properties (
  input wire logic       clk_i,      // clock
  input wire logic       rst_b_i,    // reset, low
  input wire logic       scl_i,      // scl level
  input wire logic       sda_i,      // sda level
  input wire logic       sda_o,      // sda drive level
  input wire logic       sda_oe_o,   // sda pull enable
  input wire logic [7:0] rd_addr_o,  // pointer
  input wire logic [7:0] rd_data_i,  // bank data
  input wire logic [7:0] wr_addr_o,  // write address
  input wire logic [7:0] wr_data_o,  // write data
  input wire logic       wr_valid_o, // write request
  input wire logic       wr_ready_i, // bank accepts
  input wire logic       busy_o      // transfer active
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_drive_low; sda_o == 1'b0 && (busy_o || !sda_oe_o); endproperty
  a_drive_low: assert property (p_drive_low) else $error("sda pulled or driven high while idle");
  property p_oe_scl_low; $changed(sda_oe_o) |-> !scl_i; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved while scl high");
  property p_stop_idle; $rose(sda_i) && scl_i && $past(scl_i) |-> ##[1:8] !busy_o; endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("busy after stop");
  property p_wr_hold; wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write request dropped or changed");
  property p_wr_drop; $fell(wr_valid_o) |-> $past(wr_ready_i); endproperty
  a_wr_drop: assert property (p_wr_drop) else $error("write dropped without ready");
  property p_ptr_busy; $changed(rd_addr_o) |-> busy_o && $past(busy_o); endproperty
  a_ptr_busy: assert property (p_ptr_busy) else $error("pointer moved outside transfer");
  property p_ack_busy; $rose(sda_oe_o) |-> ##[0:4] busy_o; endproperty
  a_ack_busy: assert property (p_ack_busy) else $error("sda pulled while not addressed");
  property p_reset_vals; $rose(rst_b_i) |-> rd_addr_o == 8'h00 && !wr_valid_o && !busy_o && !sda_oe_o;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs not cleared by reset");
endmodule
bind smbus_reg_port smbus_reg_port_properties chk (.*);
`default_nettype wire

//--- tb/smbus_host_model.sv
/*
  behavioural bus master: start, stop and nine-bit byte slots.
  assumes a pull-up on sda outside; pull_o high pulls sda low.
*/
`default_nettype none
module smbus_host_model (
  output var logic scl_o,  // serial clock
  output var logic pull_o, // pulls sda low
  input wire logic sda_i   // resolved sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  // also a repeated start when entered with scl low
  task automatic start();
    pull_o = 1'b0;
    #20 scl_o = 1'b1;
    #30 pull_o = 1'b1;
    #30 scl_o = 1'b0;
    #10;
  endtask
  task automatic stop();
    pull_o = 1'b1;
    #20 scl_o = 1'b1;
    #30 pull_o = 1'b0;
    #30;
  endtask
  // eight bits msb first then ack slot; a=1 leaves sda released
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
    logic [8:0] v;
    logic [8:0] r;
    v = {d, a};
    for (int i = 8; i >= 0; i--) begin
      pull_o = ~v[i];
      #30 scl_o = 1'b1;
      #25 r[i] = sda_i;
      #25 scl_o = 1'b0;
      #10;
    end
    q = r[8:1];
    ack = ~r[0];
  endtask
endmodule
`default_nettype wire

//--- tb/smbus_reg_port_tb.sv
/*
  bench of smbus_reg_port: table of bus operations, then hand tests.
  assumes smbus_host_model as master and a local array as register bank.
*/
`default_nettype none
module smbus_reg_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [1:0] op; logic [7:0] ptr; logic [7:0] dat;} row_s;
  logic       clk = 1'b0, rst_b = 1'b0, wr_ready = 1'b1, ack;
  logic       scl, pull, sda, sda_o, sda_oe, wr_valid, busy;
  logic [7:0] rd_addr, wr_addr, wr_data, q, ptr, bank [256], shadow [256];
  int         fails = 0, n_compared = 0, cyc = 0;
  // op 0 write byte, 1 pointer write then repeated start read, 2 receive byte
  row_s       rows [7] = '{'{0, 8'h10, 8'hAB}, '{2, 8'h10, 0}, '{0, 8'hFF, 8'h5A}, '{1, 8'h10, 0},
                          '{1, 8'h00, 0}, '{2, 8'h00, 0}, '{0, 8'h00, 8'h01}};
  assign sda = ~(pull | sda_oe);
  smbus_host_model host (.scl_o(scl), .pull_o(pull), .sda_i(sda));
  smbus_reg_port dut (.clk_i(clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .rd_addr_o(rd_addr), .rd_data_i(bank[rd_addr]), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .busy_o(busy));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (wr_valid && wr_ready) bank[wr_addr] <= wr_data;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic send(input logic [7:0] d, input logic a);
    host.xfer(d, 1'b1, q, ack);
    chk({7'h0, ack}, {7'h0, a});
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host.start();
    send(8'h5C, 1'b1);
    send(p, 1'b1);
    send(d, 1'b1);
    host.stop();
    shadow[p] = d;
    ptr = p;
  endtask
  task automatic rd();
    send(8'h5D, 1'b1);
    host.xfer(8'hFF, 1'b1, q, ack);
    chk(q, shadow[ptr]);
    host.stop();
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    for (int i = 0; i < 256; i++) bank[i] = i[7:0] ^ 8'hC3;
    for (int i = 0; i < 256; i++) shadow[i] = bank[i];
    ptr = 8'h00;
    pause(2);
    rst_b = 1'b1;
    pause(4);
    foreach (rows[i]) begin
      if (rows[i].op == 0) begin
        wr(rows[i].ptr, rows[i].dat);
        pause(20);
        chk(bank[ptr], rows[i].dat);
      end else begin
        host.start();
        if (rows[i].op == 1) begin
          send(8'h5C, 1'b1);
          send(rows[i].ptr, 1'b1);
          ptr = rows[i].ptr;
          host.start();
        end
        rd();
      end
    end
    host.start();
    send(8'h5E, 1'b0);
    chk({7'h0, busy}, 8'h00);
    send(8'h33, 1'b0);
    host.stop();
    chk(rd_addr, ptr);
    host.start();
    send(8'h5C, 1'b1);
    chk({7'h0, busy}, 8'h01);
    send(8'h20, 1'b1);
    send(8'h77, 1'b1);
    send(8'h99, 1'b0);
    host.stop();
    pause(20);
    chk(bank[8'h20], 8'h77);
    wr_ready = 1'b0;
    wr(8'h30, 8'h11);
    wr(8'h31, 8'h22);
    pause(40);
    chk({7'h0, wr_valid}, 8'h01);
    chk(bank[8'h30], 8'hC3 ^ 8'h30);
    wr_ready = 1'b1;
    pause(20);
    chk(bank[8'h30], 8'h11);
    chk(bank[8'h31], 8'h22);
    chk({7'h0, wr_valid}, 8'h00);
    rst_b = 1'b0;
    pause(3);
    rst_b = 1'b1;
    pause(4);
    chk(rd_addr, 8'h00);
    ptr = 8'h00;
    host.start();
    rd();
    end_sim();
  end
endmodule
`default_nettype wire
